// ### hdl/bus_port_device.sv
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module bus_port_device
   import hostport_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic srst,
   // Link to the host.
   host_link_if.device link,
   // Register RAM.
   output logic [9:0] ram_addr,
   output logic [7:0] ram_wdata,
   output logic ram_we,
   output logic ram_re,
   input wire logic [7:0] ram_rdata,
   // Addressing and service request setup.
   input wire logic [2:0] channel_sel,
   input wire logic chain_enable,
   input wire logic [2:0][7:0] service_match,
   input wire logic [2:0][7:0] service_vector,
   // Service request logic.
   input wire logic [2:0] pending,
   output logic [2:0] request_status_reg
);
   import hostport_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACCESS, ST_FETCH, ST_DONE, ST_WAIT} dev_state_e_t;

   typedef struct packed {
      logic [19:0] sync1;
      logic [19:0] sync2;
      logic phase;
      dev_state_e_t state;
      logic is_write;
      logic is_ack;
      logic [6:0] addr;
      logic [2:0] grant;
      logic [9:0] ram_addr;
      logic [7:0] ram_wdata;
      logic ram_we;
      logic ram_re;
      logic [7:0] dout;
      logic doe;
      logic done_n;
      logic pass_n;
      logic [2:0] served;
      logic [2:0] hold_cnt;
      logic [2:0] req_n;
      logic [2:0] status;
   } dev_regs_t;

   dev_regs_t s_reg;
   dev_regs_t s_next;

   logic pin_cs_n;
   logic pin_ack_n;
   logic pin_a_n;
   logic pin_b_n;
   logic pin_style;
   logic [6:0] pin_addr;
   logic [7:0] pin_data;
   logic [1:0] strobes;
   logic rd_act;
   logic wr_act;
   logic selected;
   logic [2:0] hit;
   logic [2:0] avail;
   logic [2:0] visible;

   assign {pin_cs_n, pin_ack_n, pin_a_n, pin_b_n, pin_style, pin_addr, pin_data} = s_reg.sync2;
   assign strobes = strobe_decode(pin_style, pin_a_n, pin_b_n);
   assign rd_act = strobes[1];
   assign wr_act = strobes[0];
   assign selected = (rd_act | wr_act) & (~pin_cs_n | ~pin_ack_n);

   // Only the address bits present on the port take part in the match.
   always_comb
   begin
      for (int k = 0; k < 3; k++)
      begin
         hit[k] = (s_reg.addr == service_match[k][6:0]);
      end
   end

   assign avail = pending & ~s_reg.served;
   assign visible = (s_reg.hold_cnt != 3'h0) ? 3'h0 : avail;

   always_comb
   begin
      s_next = s_reg;
      s_next.sync1 = {link.cs_n, link.ack_in_n, link.strobe_a_n, link.strobe_b_n, link.strobe_style_select,
         link.addr, link.data_bus};
      s_next.sync2 = s_reg.sync1;
      s_next.phase = ~s_reg.phase;
      s_next.ram_we = 1'b0;
      s_next.ram_re = 1'b0;
      if (s_reg.hold_cnt != 3'h0)
      begin
         s_next.hold_cnt = s_reg.hold_cnt - 3'h1;
      end
      case (s_reg.state)
         ST_IDLE:
         begin
            // Phase low marks the falling edge of the device clock.
            if (!s_reg.phase && selected)
            begin
               s_next.state = ST_SETUP;
               s_next.is_write = wr_act;
               s_next.is_ack = ~pin_ack_n;
               s_next.addr = pin_addr;
               if (pin_addr[GLOBAL_BIT])
               begin
                  s_next.ram_addr = {3'h0, pin_addr};
               end
               else
               begin
                  s_next.ram_addr = {channel_sel, pin_addr};
               end
            end
         end
         ST_SETUP:
         begin
            s_next.grant = 3'h0;
            if (!s_reg.is_ack)
            begin
               // Write data is taken as the low half ends.
               s_next.state = ST_ACCESS;
               s_next.ram_we = s_reg.is_write;
               s_next.ram_re = ~s_reg.is_write;
               s_next.ram_wdata = pin_data;
            end
            else if (hit == 3'h0)
            begin
               s_next.state = ST_WAIT;
            end
            else if ((hit & avail) != 3'h0)
            begin
               s_next.state = ST_DONE;
               s_next.done_n = 1'b0;
               if (hit[0] && avail[0])
               begin
                  s_next.grant = 3'h1;
                  s_next.dout = service_vector[0];
               end
               else if (hit[1] && avail[1])
               begin
                  s_next.grant = 3'h2;
                  s_next.dout = service_vector[1];
               end
               else
               begin
                  s_next.grant = 3'h4;
                  s_next.dout = service_vector[2];
               end
               s_next.doe = rd_act;
            end
            else if (chain_enable)
            begin
               s_next.state = ST_WAIT;
               s_next.pass_n = 1'b0;
            end
            else
            begin
               s_next.state = ST_DONE;
               s_next.dout = NO_VECTOR;
               s_next.done_n = 1'b0;
               s_next.doe = rd_act;
            end
         end
         ST_ACCESS:
         begin
            if (s_reg.is_write)
            begin
               s_next.state = ST_DONE;
               s_next.done_n = 1'b0;
            end
            else
            begin
               s_next.state = ST_FETCH;
            end
         end
         ST_FETCH:
         begin
            s_next.state = ST_DONE;
            s_next.dout = ram_rdata;
            s_next.done_n = 1'b0;
            s_next.doe = rd_act;
         end
         ST_DONE:
         begin
            s_next.doe = rd_act & ~s_reg.is_write;
            if (!selected)
            begin
               s_next.state = ST_IDLE;
               s_next.done_n = 1'b1;
               s_next.doe = 1'b0;
               s_next.served = s_reg.served | s_reg.grant;
               if (s_reg.is_write && s_reg.addr == EOS_ADDR)
               begin
                  s_next.served = 3'h0;
                  s_next.hold_cnt = EOS_HOLD_LOAD;
               end
            end
         end
         ST_WAIT:
         begin
            // A passed acknowledge lasts as long as the host holds its strobe.
            if (!selected)
            begin
               s_next.state = ST_IDLE;
               s_next.pass_n = 1'b1;
            end
         end
         default:
         begin
            s_next.state = ST_IDLE;
         end
      endcase
      s_next.status = visible;
      s_next.req_n = ~visible;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_reg <= '0;
         s_reg.sync1 <= '1;
         s_reg.sync2 <= '1;
         s_reg.state <= ST_IDLE;
         s_reg.done_n <= 1'b1;
         s_reg.pass_n <= 1'b1;
         s_reg.req_n <= REQ_IDLE;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign link.dev_data = s_reg.dout;
   assign link.dev_data_oe = s_reg.doe;
   assign link.cycle_done_n = s_reg.done_n;
   assign link.ack_pass_n = s_reg.pass_n;
   assign link.rx_request_n = s_reg.req_n[0];
   assign link.tx_request_n = s_reg.req_n[1];
   assign link.modem_request_n = s_reg.req_n[2];
   assign ram_addr = s_reg.ram_addr;
   assign ram_wdata = s_reg.ram_wdata;
   assign ram_we = s_reg.ram_we;
   assign ram_re = s_reg.ram_re;
   assign request_status_reg = s_reg.status;
endmodule // bus_port_device

// ### hdl/bus_port_host.sv
`timescale 1ns/100ps
module bus_port_host
   import hostport_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic srst,
   // AXI4-Lite write channels.
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Link to the device.
   host_link_if.host link
);
   import hostport_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_ADDR, H_STROBE, H_RELEASE} host_state_e_t;

   typedef struct packed {
      logic [12:0] sync1;
      logic [12:0] sync2;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [5:0] aw_word;
      logic [31:0] w_data;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      host_state_e_t state;
      logic [6:0] tcnt;
      logic is_write;
      logic is_ack;
      logic style;
      logic [6:0] addr;
      logic [7:0] hdata;
      logic hoe;
      logic cs_n;
      logic ack_in_n;
      logic [1:0] strobe_n;
      logic busy;
      logic done;
      logic tout;
      logic passed;
      logic [7:0] rdata8;
   } host_regs_t;

   host_regs_t s_reg;
   host_regs_t s_next;

   logic in_done_n;
   logic in_pass_n;
   logic [2:0] in_req_n;
   logic [7:0] in_bus;
   logic [31:0] status_word;

   assign {in_done_n, in_pass_n, in_req_n, in_bus} = s_reg.sync2;
   assign status_word = {8'h00, s_reg.rdata8, 5'h00, ~in_req_n, 4'h0, s_reg.passed, s_reg.tout, s_reg.done,
      s_reg.busy};

   always_comb
   begin
      s_next = s_reg;
      // Request lines change at any moment and pass two flip-flops first.
      s_next.sync1 = {link.cycle_done_n, link.ack_pass_n, link.modem_request_n, link.tx_request_n,
         link.rx_request_n, link.data_bus};
      s_next.sync2 = s_reg.sync1;
      if (awvalid && s_reg.awready)
      begin
         s_next.aw_got = 1'b1;
         s_next.aw_word = awaddr[7:2];
      end
      if (wvalid && s_reg.wready)
      begin
         s_next.w_got = 1'b1;
         s_next.w_data = wdata;
      end
      if (bvalid && bready)
      begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
      begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = (s_reg.aw_word == CMD_WORD) ? RESP_OKAY : RESP_SLVERR;
         if (s_reg.aw_word == CMD_WORD && !s_reg.busy && s_reg.state == H_IDLE)
         begin
            s_next.busy = 1'b1;
            s_next.done = 1'b0;
            s_next.tout = 1'b0;
            s_next.passed = 1'b0;
            s_next.hdata = s_reg.w_data[CMD_DATA_LSB +: 8];
            s_next.addr = s_reg.w_data[CMD_ADDR_LSB +: 7];
            s_next.is_write = s_reg.w_data[CMD_WRITE_BIT] & ~s_reg.w_data[CMD_ACK_BIT];
            s_next.is_ack = s_reg.w_data[CMD_ACK_BIT];
            s_next.style = s_reg.w_data[CMD_STYLE_BIT];
            s_next.hoe = s_reg.w_data[CMD_WRITE_BIT] & ~s_reg.w_data[CMD_ACK_BIT];
            s_next.state = H_ADDR;
         end
      end
      if (rvalid && rready)
      begin
         s_next.rvalid = 1'b0;
      end
      if (arvalid && s_reg.arready)
      begin
         s_next.rvalid = 1'b1;
         s_next.rresp = (araddr[7:2] == STATUS_WORD || araddr[7:2] == CMD_WORD) ? RESP_OKAY : RESP_SLVERR;
         s_next.rdata = (araddr[7:2] == STATUS_WORD) ? status_word : 32'h0;
      end
      case (s_reg.state)
         H_IDLE:
         begin
         end
         H_ADDR:
         begin
            // The address has stood for a cycle before any select goes low.
            s_next.state = H_STROBE;
            s_next.cs_n = s_reg.is_ack;
            s_next.ack_in_n = ~s_reg.is_ack;
            s_next.strobe_n = strobe_encode(s_reg.style, ~s_reg.is_write, s_reg.is_write);
            s_next.tcnt = 7'h0;
         end
         H_STROBE:
         begin
            s_next.tcnt = s_reg.tcnt + 7'h1;
            if (!in_done_n)
            begin
               // Strobe held until the data has been sampled.
               s_next.rdata8 = in_bus;
               s_next.done = 1'b1;
               s_next.state = H_RELEASE;
            end
            else if (!in_pass_n)
            begin
               s_next.passed = 1'b1;
               s_next.state = H_RELEASE;
            end
            else if (s_reg.tcnt == TIMEOUT_CLKS)
            begin
               s_next.tout = 1'b1;
               s_next.state = H_RELEASE;
            end
            if (s_next.state == H_RELEASE)
            begin
               s_next.strobe_n = 2'h3;
               s_next.cs_n = 1'b1;
               s_next.ack_in_n = 1'b1;
               s_next.hoe = 1'b0;
            end
         end
         H_RELEASE:
         begin
            // Wait for the device to let go so a stale answer is never seen.
            if (in_done_n && in_pass_n)
            begin
               s_next.busy = 1'b0;
               s_next.state = H_IDLE;
            end
         end
         default:
         begin
            s_next.state = H_IDLE;
         end
      endcase
      s_next.awready = ~s_next.aw_got & ~s_next.bvalid;
      s_next.wready = ~s_next.w_got & ~s_next.bvalid;
      s_next.arready = ~s_next.rvalid;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_reg <= '0;
         s_reg.sync1 <= '1;
         s_reg.sync2 <= '1;
         s_reg.state <= H_IDLE;
         s_reg.cs_n <= 1'b1;
         s_reg.ack_in_n <= 1'b1;
         s_reg.strobe_n <= 2'h3;
         s_reg.style <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign awready = s_reg.awready;
   assign wready = s_reg.wready;
   assign bvalid = s_reg.bvalid;
   assign bresp = s_reg.bresp;
   assign arready = s_reg.arready;
   assign rvalid = s_reg.rvalid;
   assign rresp = s_reg.rresp;
   assign rdata = s_reg.rdata;
   assign link.cs_n = s_reg.cs_n;
   assign link.ack_in_n = s_reg.ack_in_n;
   assign {link.strobe_a_n, link.strobe_b_n} = s_reg.strobe_n;
   assign link.strobe_style_select = s_reg.style;
   assign link.addr = s_reg.addr;
   assign link.host_data = s_reg.hdata;
   assign link.host_data_oe = s_reg.hoe;
endmodule // bus_port_host

// ### shared/host_link_if.sv
`timescale 1ns/100ps
interface host_link_if;
   logic cs_n;
   logic ack_in_n;
   logic strobe_a_n;
   logic strobe_b_n;
   logic strobe_style_select;
   logic [6:0] addr;
   logic [7:0] host_data;
   logic host_data_oe;
   logic [7:0] dev_data;
   logic dev_data_oe;
   logic [7:0] data_bus;
   logic cycle_done_n;
   logic ack_pass_n;
   logic rx_request_n;
   logic tx_request_n;
   logic modem_request_n;

   // An undriven bus floats high.
   assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : hostport_pkg::FLOAT_BUS);

   modport device(input cs_n, input ack_in_n, input strobe_a_n, input strobe_b_n, input strobe_style_select,
      input addr, input data_bus, output dev_data, output dev_data_oe, output cycle_done_n,
      output ack_pass_n, output rx_request_n, output tx_request_n, output modem_request_n);
   modport host(output cs_n, output ack_in_n, output strobe_a_n, output strobe_b_n,
      output strobe_style_select, output addr, output host_data, output host_data_oe, input data_bus,
      input cycle_done_n, input ack_pass_n, input rx_request_n, input tx_request_n, input modem_request_n);
endinterface

// ### shared/hostport_pkg.sv
package hostport_pkg;
   localparam int CLK_PERIOD_NS = 20;
   // Our clock cycles per half period of the device clock.
   localparam int DEV_HALF_CLKS = 1;
   localparam int DEV_PERIOD_NS = 2 * DEV_HALF_CLKS * CLK_PERIOD_NS;
   localparam int CYCLE_EXTRA_NS = 10;
   localparam int MAX_CYCLE_NS = 2 * DEV_PERIOD_NS + CYCLE_EXTRA_NS;
   localparam int MAX_CYCLE_CLKS = MAX_CYCLE_NS / CLK_PERIOD_NS;
   localparam int EOS_HOLD_NS = 2 * DEV_PERIOD_NS;
   localparam int EOS_HOLD_CLKS = (EOS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] EOS_HOLD_LOAD = 3'(EOS_HOLD_CLKS);
   localparam logic [6:0] EOS_ADDR = 7'h7e;
   localparam int GLOBAL_BIT = 6;
   localparam logic [6:0] TIMEOUT_CLKS = 7'h40;
   localparam logic [7:0] FLOAT_BUS = 8'hff;
   localparam logic [7:0] NO_VECTOR = 8'h00;
   localparam logic [2:0] REQ_IDLE = 3'h7;
   localparam logic [5:0] CMD_WORD = 6'h00;
   localparam logic [5:0] STATUS_WORD = 6'h01;
   localparam int CMD_DATA_LSB = 0;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_WRITE_BIT = 16;
   localparam int CMD_ACK_BIT = 17;
   localparam int CMD_STYLE_BIT = 18;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_TIMEOUT_BIT = 2;
   localparam int STAT_PASSED_BIT = 3;
   localparam int STAT_REQ_LSB = 8;
   localparam int STAT_DATA_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Returns {read_active, write_active} from the two strobe pins.
   function automatic logic [1:0] strobe_decode(input logic style, input logic a_n, input logic b_n);
      return style ? {~a_n, ~b_n} : {~a_n & b_n, ~a_n & ~b_n};
   endfunction

   // Returns the levels {a_n, b_n} that express a read or write strobe.
   function automatic logic [1:0] strobe_encode(input logic style, input logic rd, input logic wr);
      return style ? {~rd, ~wr} : {~(rd | wr), ~wr};
   endfunction
endpackage

// ### tb/link_monitor.sv
`timescale 1ns/100ps
module link_monitor
(
   // Clock and reset.
   input wire logic clock,
   input wire logic srst,
   // Host side of the link.
   input wire logic cs_n,
   input wire logic ack_in_n,
   input wire logic strobe_a_n,
   input wire logic strobe_b_n,
   input wire logic strobe_style_select,
   input wire logic [6:0] addr,
   // Device side of the link.
   input wire logic dev_data_oe,
   input wire logic cycle_done_n,
   input wire logic ack_pass_n
);
   logic read_on;
   assign read_on = strobe_style_select ? !strobe_a_n : (!strobe_a_n && strobe_b_n);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   sel_excl_a: assert property (cs_n || ack_in_n)
      else $error("select and acknowledge low together");
   done_sel_a: assert property ($fell(cycle_done_n) |-> (!cs_n || !ack_in_n))
      else $error("cycle done without selection");
   done_bound_a: assert property ($fell(cs_n) |-> ##[1:12] !cycle_done_n)
      else $error("cycle done late");
   oe_read_a: assert property ($rose(dev_data_oe) |-> read_on && (!cs_n || !ack_in_n))
      else $error("data driven without read strobe");
   pass_ack_a: assert property ($fell(ack_pass_n) |-> !ack_in_n && cs_n)
      else $error("pass without acknowledge");
   done_pass_a: assert property (cycle_done_n || ack_pass_n)
      else $error("done and pass together");
   ack_addr_a: assert property ($fell(ack_in_n) |-> $stable(addr))
      else $error("address moved with acknowledge");
   release_idle_a: assert property ((cs_n && ack_in_n) [*6] |-> cycle_done_n && ack_pass_n && !dev_data_oe)
      else $error("device outputs held after release");
   cover property ($fell(cycle_done_n) && !ack_in_n);
   cover property ($fell(ack_pass_n));
   cover property ($rose(dev_data_oe) && !cs_n);
endmodule // link_monitor

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
   import hostport_pkg::*;
   logic clock, srst;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic [9:0] ram_addr, wr_addr, rd_addr;
   logic [7:0] ram_wdata, ram_rdata, wr_data;
   logic ram_we, ram_re, chain_enable;
   logic [2:0] channel_sel, pending, request_status_reg;
   logic [2:0][7:0] service_match, service_vector;
   logic [31:0] stat;
   int num_errors = 0;
   int samples_checked = 0;
   host_link_if host_link_if_inst();
   bus_port_device bus_port_device_inst(.clock(clock), .srst(srst), .link(host_link_if_inst), .ram_addr(ram_addr),
      .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata), .channel_sel(channel_sel),
      .chain_enable(chain_enable), .service_match(service_match), .service_vector(service_vector),
      .pending(pending), .request_status_reg(request_status_reg));
   bus_port_host bus_port_host_inst(.clock(clock), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(host_link_if_inst));
   link_monitor link_monitor_inst(.clock(clock), .srst(srst), .cs_n(host_link_if_inst.cs_n),
      .ack_in_n(host_link_if_inst.ack_in_n), .strobe_a_n(host_link_if_inst.strobe_a_n),
      .strobe_b_n(host_link_if_inst.strobe_b_n), .strobe_style_select(host_link_if_inst.strobe_style_select),
      .addr(host_link_if_inst.addr), .dev_data_oe(host_link_if_inst.dev_data_oe),
      .cycle_done_n(host_link_if_inst.cycle_done_n), .ack_pass_n(host_link_if_inst.ack_pass_n));
   // Register RAM stand-in: read data, a fixed function of the address, follows a read pulse by one cycle.
   always @(posedge clock)
   begin
      if (ram_re)
      begin
         rd_addr <= ram_addr;
         ram_rdata <= ram_addr[7:0] ^ 8'h5a;
      end
      if (ram_we)
      begin
         wr_addr <= ram_addr;
         wr_data <= ram_wdata;
      end
   end
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("FAIL %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task automatic hang(input string what);
      $display("FAIL %s expected handshake seen none", what);
      num_errors++;
      end_of_test();
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n <= 100; n++)
      begin
         @(posedge clock);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            bready <= 1'b0;
            check("bresp", {30'h0, resp}, {30'h0, bresp});
            return;
         end
      end
      hang("write");
   endtask
   task automatic axi_read(input logic [7:0] a, input logic [1:0] resp, output logic [31:0] d);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n <= 100; n++)
      begin
         @(posedge clock);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            rready <= 1'b0;
            d = rdata;
            check("rresp", {30'h0, resp}, {30'h0, rresp});
            return;
         end
      end
      hang("read");
   endtask
   // Issues one link cycle and polls the status word until the host side is idle again.
   task automatic run_cmd(input logic [6:0] a, input logic [7:0] d, input logic wr, input logic ack, input logic sty);
      axi_write({CMD_WORD, 2'b00}, {13'h0, sty, ack, wr, 1'b0, a, d}, RESP_OKAY);
      for (int n = 0; n <= 60; n++)
      begin
         axi_read({STATUS_WORD, 2'b00}, RESP_OKAY, stat);
         if (stat[STAT_BUSY_BIT] === 1'b0 && (stat[STAT_DONE_BIT] | stat[STAT_TIMEOUT_BIT] | stat[STAT_PASSED_BIT]))
            return;
      end
      hang("command");
   endtask
   task automatic t_access();
      logic [31:0] d;
      for (int s = 0; s < 2; s++)
      begin
         channel_sel <= 3'h5;
         run_cmd(7'h05, 8'hc3 ^ 8'(s), 1'b1, 1'b0, 1'(s));
         check("write done", 32'h1, {31'h0, stat[STAT_DONE_BIT]});
         check("write addr", {22'h0, 10'h285}, {22'h0, wr_addr});
         check("write data", {24'h0, 8'hc3 ^ 8'(s)}, {24'h0, wr_data});
         run_cmd(7'h41, 8'h00, 1'b0, 1'b0, 1'(s));
         check("read data", {24'h0, 8'h41 ^ 8'h5a}, {24'h0, stat[STAT_DATA_LSB +: 8]});
         check("read addr", {22'h0, 10'h041}, {22'h0, rd_addr});
      end
      axi_read(8'h08, RESP_SLVERR, d);
      check("unmapped data", 32'h0, d);
      axi_write(8'h0c, 32'h1, RESP_SLVERR);
      $display("test access done");
   endtask
   task automatic t_ack();
      pending <= 3'b010;
      chain_enable <= 1'b1;
      repeat (8) @(posedge clock);
      check("request pin", 32'h0, {31'h0, host_link_if_inst.tx_request_n});
      run_cmd(7'h74, 8'h00, 1'b0, 1'b1, 1'b1);
      check("vector", {24'h0, 8'h20}, {24'h0, stat[STAT_DATA_LSB +: 8]});
      check("served status", 32'h0, {29'h0, request_status_reg});
      check("served pin", 32'h1, {31'h0, host_link_if_inst.tx_request_n});
      run_cmd(7'h74, 8'h00, 1'b0, 1'b1, 1'b1);
      check("chain pass", 32'h1, {31'h0, stat[STAT_PASSED_BIT]});
      chain_enable <= 1'b0;
      run_cmd(7'h72, 8'h00, 1'b0, 1'b1, 1'b0);
      check("empty done", 32'h1, {31'h0, stat[STAT_DONE_BIT]});
      check("empty vector", {24'h0, NO_VECTOR}, {24'h0, stat[STAT_DATA_LSB +: 8]});
      chain_enable <= 1'b1;
      run_cmd(7'h11, 8'h00, 1'b0, 1'b1, 1'b1);
      check("unmatched timeout", 32'h1, {31'h0, stat[STAT_TIMEOUT_BIT]});
      check("unmatched pass", 32'h0, {31'h0, stat[STAT_PASSED_BIT]});
      $display("test ack done");
   endtask
   task automatic t_eos();
      int zeros;
      logic [31:0] d;
      zeros = 0;
      pending <= 3'b011;
      repeat (4) @(posedge clock);
      check("eos before", 32'h1, {29'h0, request_status_reg});
      axi_write({CMD_WORD, 2'b00}, {16'h1, 1'b0, EOS_ADDR, 8'h00} | 32'h40000, RESP_OKAY);
      for (int n = 0; n <= 80 && request_status_reg !== 3'b000; n++)
         @(posedge clock);
      for (int n = 0; n <= 80 && request_status_reg === 3'b000; n++)
      begin
         @(posedge clock);
         zeros++;
      end
      check("eos status", 32'h3, {29'h0, request_status_reg});
      check("eos hold", 2 * 2 * DEV_HALF_CLKS, zeros);
      repeat (6) @(posedge clock);
      check("eos pin", 32'h0, {31'h0, host_link_if_inst.tx_request_n});
      axi_read({STATUS_WORD, 2'b00}, RESP_OKAY, d);
      check("synced requests", 32'h3, {29'h0, d[STAT_REQ_LSB +: 3]});
      $display("test eos done");
   endtask
   initial
   begin
      srst = 1'b1;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      channel_sel = 3'h0;
      chain_enable = 1'b0;
      pending = 3'b000;
      service_match = {8'h76, 8'h74, 8'h72};
      service_vector = {8'h30, 8'h20, 8'h10};
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      repeat (4) @(posedge clock);
      t_access();
      t_ack();
      t_eos();
      end_of_test();
   end
endmodule // tb
